// *** aipc_defs.vh ***
// Purpose : shared constants for the analogue input path register bank
// Assumes : 32-bit AXI4-Lite data, one aligned word per register
// Notes   : byte address of a register is four times its index
`ifndef AIPC_DEFS_VH
`define AIPC_DEFS_VH

// ==========================================================================
// bus and addressing
`define AIPC_ADDR_W        8
`define AIPC_IDX_W         6
`define AIPC_IDX_RGAIN     6'h2D
`define AIPC_IDX_LROUTE    6'h2E
`define AIPC_IDX_RROUTE    6'h2F
`define AIPC_RESP_OKAY     2'h0
`define AIPC_RESP_SLVERR   2'h2

// ==========================================================================
// field positions
`define AIPC_MUTE_BIT      7
`define AIPC_GAIN_HI       4
`define AIPC_CMR_BIT       6
`define AIPC_NSEL_HI       5
`define AIPC_NSEL_LO       4
`define AIPC_PSEL_HI       3
`define AIPC_PSEL_LO       2
`define AIPC_MODE_HI       1

// ==========================================================================
// reset values and writable masks
`define AIPC_RST_RGAIN     16'h0085
`define AIPC_RST_ROUTE     16'h0044
`define AIPC_MASK_RGAIN    16'h009F
`define AIPC_MASK_ROUTE    16'h007F

// ==========================================================================
// input modes
`define AIPC_MODE_SE       2'h0
`define AIPC_MODE_DLINE    2'h1
`define AIPC_MODE_DMIC     2'h2
`define AIPC_MODE_RSVD     2'h3

`endif

// *** aipc_gain_lut.v ***
// Purpose : decode right gain code to gain in tenths of a dB
// Assumes : mode codes with bit 1 set follow the microphone law
// Notes   : outputs are registered, one cycle behind the inputs
`timescale 1ns/1ns
`include "aipc_defs.vh"

module aipc_gain_lut (
   input  wire       clk_sys,
   input  wire       nrst,
   input  wire [4:0] gain_code,
   input  wire [1:0] mode,
   output reg  [9:0] gain_tenth_db_q,
   output reg        gain_invalid_q
);

   // ========================================================================
   // line law, two's complement tenths of a dB
   function [9:0] line_gain;
      input [4:0] c;
      begin
         case (c)
            5'h00: line_gain = 10'h3F1;
            5'h01: line_gain = 10'h3F3;
            5'h02: line_gain = 10'h3F6;
            5'h03: line_gain = 10'h3F9;
            5'h04: line_gain = 10'h3FD;
            5'h05: line_gain = 10'h000;
            5'h06: line_gain = 10'h003;
            5'h07: line_gain = 10'h007;
            5'h08: line_gain = 10'h00A;
            5'h09: line_gain = 10'h00E;
            5'h0A: line_gain = 10'h012;
            5'h0B: line_gain = 10'h017;
            5'h0C: line_gain = 10'h01B;
            5'h0D: line_gain = 10'h020;
            5'h0E: line_gain = 10'h025;
            5'h0F: line_gain = 10'h02A;
            5'h10: line_gain = 10'h030;
            5'h11: line_gain = 10'h036;
            5'h12: line_gain = 10'h03C;
            5'h13: line_gain = 10'h043;
            5'h14: line_gain = 10'h04B;
            5'h15: line_gain = 10'h053;
            5'h16: line_gain = 10'h05C;
            5'h17: line_gain = 10'h066;
            5'h18: line_gain = 10'h072;
            5'h19: line_gain = 10'h07F;
            5'h1A: line_gain = 10'h08F;
            5'h1B: line_gain = 10'h0A2;
            5'h1C: line_gain = 10'h0C0;
            5'h1D: line_gain = 10'h0DF;
            5'h1E: line_gain = 10'h0FC;
            default: line_gain = 10'h11B;
         endcase
      end
   endfunction

   // ========================================================================
   // microphone law, 3 dB steps clamped at the top
   function [9:0] mic_gain;
      input [4:0] c;
      begin
         case (c)
            5'h01: mic_gain = 10'h078;
            5'h02: mic_gain = 10'h096;
            5'h03: mic_gain = 10'h0B4;
            5'h04: mic_gain = 10'h0D2;
            5'h05: mic_gain = 10'h0F0;
            5'h06: mic_gain = 10'h10E;
            5'h00: mic_gain = 10'h000;
            default: mic_gain = 10'h12C;
         endcase
      end
   endfunction

   // ========================================================================
   // registered decode
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         gain_tenth_db_q <= 10'h000;
         gain_invalid_q  <= 1'b0;
      end else if (mode[1]) begin
         gain_tenth_db_q <= mic_gain(gain_code);
         gain_invalid_q  <= (gain_code == 5'h00);
      end else begin
         gain_tenth_db_q <= line_gain(gain_code);
         gain_invalid_q  <= 1'b0;
      end
   end

endmodule // aipc_gain_lut

// *** aipc_pin_route.v ***
// Purpose : decode one channel's pin selects into one-hot pin enables
// Assumes : select 1X means pin three; mode bit 1 means microphone mode
// Notes   : outputs are registered, one cycle behind the inputs
`timescale 1ns/1ns
`include "aipc_defs.vh"

module aipc_pin_route (
   input  wire       clk_sys,
   input  wire       nrst,
   input  wire [1:0] neg_pick,
   input  wire [1:0] pos_pick,
   input  wire [1:0] mode,
   input  wire       cmr_on,
   output reg  [2:0] inv_pins_q,
   output reg  [2:0] noninv_pins_q,
   output reg        cmr_active_q,
   output reg        mode_reserved_q
);

   // ========================================================================
   // select to one-hot: bit 0 pin one, bit 1 pin two, bit 2 pin three
   function [2:0] onehot;
      input [1:0] s;
      begin
         if (s[1])
            onehot = 3'h4;
         else if (s[0])
            onehot = 3'h2;
         else
            onehot = 3'h1;
      end
   endfunction

   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         inv_pins_q      <= 3'h1;
         noninv_pins_q   <= 3'h2;
         cmr_active_q    <= 1'b0;
         mode_reserved_q <= 1'b0;
      end else begin
         if (mode[1]) begin
            // microphone mode swaps the roles of the two selects
            inv_pins_q    <= onehot(pos_pick);
            noninv_pins_q <= onehot(neg_pick);
         end else begin
            inv_pins_q    <= onehot(neg_pick);
            noninv_pins_q <= onehot(pos_pick);
         end
         cmr_active_q    <= cmr_on & (mode == `AIPC_MODE_DLINE);
         mode_reserved_q <= (mode == `AIPC_MODE_RSVD);
      end
   end

endmodule // aipc_pin_route

// *** aipc_regs.v ***
// Purpose : AXI4-Lite register bank for the stereo analogue input path
// Assumes : single clock, asynchronous active-low reset
// Notes   : one write and one read in flight; unmapped access gives SLVERR
`timescale 1ns/1ns
`include "aipc_defs.vh"

module aipc_regs (
   input  wire                     clk_sys,
   input  wire                     nrst,
   // write address channel
   input  wire [`AIPC_ADDR_W-1:0]  s_axi_awaddr,
   input  wire [2:0]               s_axi_awprot,
   input  wire                     s_axi_awvalid,
   output wire                     s_axi_awready,
   // write data channel
   input  wire [31:0]              s_axi_wdata,
   input  wire [3:0]               s_axi_wstrb,
   input  wire                     s_axi_wvalid,
   output wire                     s_axi_wready,
   // write response channel
   output wire [1:0]               s_axi_bresp,
   output wire                     s_axi_bvalid,
   input  wire                     s_axi_bready,
   // read address channel
   input  wire [`AIPC_ADDR_W-1:0]  s_axi_araddr,
   input  wire [2:0]               s_axi_arprot,
   input  wire                     s_axi_arvalid,
   output wire                     s_axi_arready,
   // read data channel
   output wire [31:0]              s_axi_rdata,
   output wire [1:0]               s_axi_rresp,
   output wire                     s_axi_rvalid,
   input  wire                     s_axi_rready,
   // right amplifier
   output wire                     right_amp_silence,
   output wire [4:0]               right_amp_gain_code,
   output wire [9:0]               right_gain_tenth_db,
   output wire                     right_gain_invalid,
   // raw routing fields
   output wire                     left_common_rejection_on,
   output wire                     right_common_rejection_on,
   output wire [1:0]               left_negative_pin_pick,
   output wire [1:0]               left_positive_pin_pick,
   output wire [1:0]               right_negative_pin_pick,
   output wire [1:0]               right_positive_pin_pick,
   output wire [1:0]               left_input_mode,
   output wire [1:0]               right_input_mode,
   // decoded routing
   output wire                     left_cmr_active,
   output wire                     right_cmr_active,
   output wire [2:0]               left_inv_pins,
   output wire [2:0]               left_noninv_pins,
   output wire [2:0]               right_inv_pins,
   output wire [2:0]               right_noninv_pins,
   output wire                     left_mode_reserved,
   output wire                     right_mode_reserved
);

   // ========================================================================
   // register storage
   reg  [15:0]             rgain_q;
   reg  [15:0]             lroute_q;
   reg  [15:0]             rroute_q;

   // ========================================================================
   // write channel state
   reg                     aw_rdy_q;
   reg                     w_rdy_q;
   reg                     have_aw_q;
   reg                     have_w_q;
   reg                     bvalid_q;
   reg  [1:0]              bresp_q;
   reg  [`AIPC_IDX_W-1:0]  wr_idx_q;
   reg  [15:0]             wr_data_q;
   reg  [1:0]              wr_be_q;

   // ========================================================================
   // read channel state
   reg                     ar_rdy_q;
   reg                     rvalid_q;
   reg  [31:0]             rdata_q;
   reg  [1:0]              rresp_q;
   reg  [15:0]             rd_word;
   reg                     rd_hit;
   reg                     wr_hit;

   wire                    aw_hs;
   wire                    w_hs;
   wire                    wr_go;
   wire                    ar_hs;
   wire [`AIPC_IDX_W-1:0]  rd_idx;

   assign aw_hs  = s_axi_awvalid & aw_rdy_q;
   assign w_hs   = s_axi_wvalid & w_rdy_q;
   assign wr_go  = have_aw_q & have_w_q & ~bvalid_q;
   assign ar_hs  = s_axi_arvalid & ar_rdy_q;
   assign rd_idx = s_axi_araddr[`AIPC_ADDR_W-1:2];

   // ========================================================================
   // byte-lane merge; undefined bits forced to zero whatever is written
   function [15:0] merge;
      input [15:0] old;
      input [15:0] nw;
      input [1:0]  be;
      input [15:0] mask;
      reg   [15:0] lanes;
      begin
         lanes = {{8{be[1]}}, {8{be[0]}}};
         merge = ((old & ~lanes) | (nw & lanes)) & mask;
      end
   endfunction

   // ========================================================================
   // write address decode
   always @* begin
      case (wr_idx_q)
         `AIPC_IDX_RGAIN:  wr_hit = 1'b1;
         `AIPC_IDX_LROUTE: wr_hit = 1'b1;
         `AIPC_IDX_RROUTE: wr_hit = 1'b1;
         default:          wr_hit = 1'b0;
      endcase
   end

   // ========================================================================
   // write handshake: address and data taken in either order,
   // response issued once both are held
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         aw_rdy_q  <= 1'b0;
         w_rdy_q   <= 1'b0;
         have_aw_q <= 1'b0;
         have_w_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `AIPC_RESP_OKAY;
         wr_idx_q  <= {`AIPC_IDX_W{1'b0}};
         wr_data_q <= 16'h0000;
         wr_be_q   <= 2'h0;
      end else begin
         if (aw_hs) begin
            aw_rdy_q  <= 1'b0;
            have_aw_q <= 1'b1;
            wr_idx_q  <= s_axi_awaddr[`AIPC_ADDR_W-1:2];
         end else if (~have_aw_q & ~bvalid_q) begin
            aw_rdy_q <= 1'b1;
         end
         if (w_hs) begin
            w_rdy_q   <= 1'b0;
            have_w_q  <= 1'b1;
            wr_data_q <= s_axi_wdata[15:0];
            wr_be_q   <= s_axi_wstrb[1:0];
         end else if (~have_w_q & ~bvalid_q) begin
            w_rdy_q <= 1'b1;
         end
         if (wr_go) begin
            have_aw_q <= 1'b0;
            have_w_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_hit ? `AIPC_RESP_OKAY : `AIPC_RESP_SLVERR;
         end else if (bvalid_q & s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // ========================================================================
   // register update; reserved mode code is stored so it reads back,
   // and flagged rather than silently corrected
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rgain_q  <= `AIPC_RST_RGAIN;
         lroute_q <= `AIPC_RST_ROUTE;
         rroute_q <= `AIPC_RST_ROUTE;
      end else if (wr_go) begin
         case (wr_idx_q)
            `AIPC_IDX_RGAIN:
               rgain_q <= merge(rgain_q, wr_data_q, wr_be_q,
                                `AIPC_MASK_RGAIN);
            `AIPC_IDX_LROUTE:
               lroute_q <= merge(lroute_q, wr_data_q, wr_be_q,
                                 `AIPC_MASK_ROUTE);
            `AIPC_IDX_RROUTE:
               rroute_q <= merge(rroute_q, wr_data_q, wr_be_q,
                                 `AIPC_MASK_ROUTE);
            default: begin
            end
         endcase
      end
   end

   // ========================================================================
   // read decode
   always @* begin
      rd_word = 16'h0000;
      rd_hit  = 1'b1;
      case (rd_idx)
         `AIPC_IDX_RGAIN:  rd_word = rgain_q;
         `AIPC_IDX_LROUTE: rd_word = lroute_q;
         `AIPC_IDX_RROUTE: rd_word = rroute_q;
         default:          rd_hit  = 1'b0;
      endcase
   end

   // ========================================================================
   // read handshake; answer one cycle after the address is taken
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ar_rdy_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h00000000;
         rresp_q  <= `AIPC_RESP_OKAY;
      end else if (ar_hs) begin
         ar_rdy_q <= 1'b0;
         rvalid_q <= 1'b1;
         rdata_q  <= {16'h0000, rd_word};
         rresp_q  <= rd_hit ? `AIPC_RESP_OKAY : `AIPC_RESP_SLVERR;
      end else if (rvalid_q & s_axi_rready) begin
         rvalid_q <= 1'b0;
         ar_rdy_q <= 1'b1;
      end else if (~rvalid_q) begin
         ar_rdy_q <= 1'b1;
      end
   end

   assign s_axi_awready = aw_rdy_q;
   assign s_axi_wready  = w_rdy_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = ar_rdy_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   // ========================================================================
   // raw fields, straight from the register flops
   assign right_amp_silence         = rgain_q[`AIPC_MUTE_BIT];
   assign right_amp_gain_code       = rgain_q[`AIPC_GAIN_HI:0];
   assign left_common_rejection_on  = lroute_q[`AIPC_CMR_BIT];
   assign right_common_rejection_on = rroute_q[`AIPC_CMR_BIT];
   assign left_negative_pin_pick    =
      lroute_q[`AIPC_NSEL_HI:`AIPC_NSEL_LO];
   assign left_positive_pin_pick    =
      lroute_q[`AIPC_PSEL_HI:`AIPC_PSEL_LO];
   assign right_negative_pin_pick   =
      rroute_q[`AIPC_NSEL_HI:`AIPC_NSEL_LO];
   assign right_positive_pin_pick   =
      rroute_q[`AIPC_PSEL_HI:`AIPC_PSEL_LO];
   assign left_input_mode           = lroute_q[`AIPC_MODE_HI:0];
   assign right_input_mode          = rroute_q[`AIPC_MODE_HI:0];

   // ========================================================================
   // gain law follows the right mode field
   aipc_gain_lut u_gain (
      .clk_sys         (clk_sys),
      .nrst            (nrst),
      .gain_code       (rgain_q[`AIPC_GAIN_HI:0]),
      .mode            (rroute_q[`AIPC_MODE_HI:0]),
      .gain_tenth_db_q (right_gain_tenth_db),
      .gain_invalid_q  (right_gain_invalid)
   );

   // ========================================================================
   // per-channel pin routing; channel 0 left, channel 1 right
   wire [31:0] route_pk;
   wire [5:0]  inv_pk;
   wire [5:0]  noninv_pk;
   wire [1:0]  cmr_pk;
   wire [1:0]  rsvd_pk;

   assign route_pk = {rroute_q, lroute_q};

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
         aipc_pin_route u_route (
            .clk_sys         (clk_sys),
            .nrst            (nrst),
            .neg_pick        (route_pk[ch*16+`AIPC_NSEL_LO +: 2]),
            .pos_pick        (route_pk[ch*16+`AIPC_PSEL_LO +: 2]),
            .mode            (route_pk[ch*16 +: 2]),
            .cmr_on          (route_pk[ch*16+`AIPC_CMR_BIT]),
            .inv_pins_q      (inv_pk[ch*3 +: 3]),
            .noninv_pins_q   (noninv_pk[ch*3 +: 3]),
            .cmr_active_q    (cmr_pk[ch]),
            .mode_reserved_q (rsvd_pk[ch])
         );
      end
   endgenerate

   assign left_inv_pins       = inv_pk[2:0];
   assign right_inv_pins      = inv_pk[5:3];
   assign left_noninv_pins    = noninv_pk[2:0];
   assign right_noninv_pins   = noninv_pk[5:3];
   assign left_cmr_active     = cmr_pk[0];
   assign right_cmr_active    = cmr_pk[1];
   assign left_mode_reserved  = rsvd_pk[0];
   assign right_mode_reserved = rsvd_pk[1];

   // prot inputs accepted but unused: no access protection on this bank
   wire unused_prot;
   assign unused_prot = ^{s_axi_awprot, s_axi_arprot, s_axi_wdata[31:16],
                          s_axi_wstrb[3:2]};

endmodule // aipc_regs

// *** aipc_regs_asserts.sv ***
// Purpose : port checks for the input path register bank
// Assumes : one clock, asynchronous active-low reset
// Notes   : decoded outputs trail the register fields by one cycle
`timescale 1ns/1ns
module aipc_regs_asserts (
   input logic       clk_sys,
   input logic       nrst,
   input logic       s_axi_arvalid,
   input logic       s_axi_arready,
   input logic       s_axi_rvalid,
   input logic       s_axi_rready,
   input logic       right_amp_silence,
   input logic [4:0] right_amp_gain_code,
   input logic [9:0] right_gain_tenth_db,
   input logic       right_gain_invalid,
   input logic [1:0] right_input_mode,
   input logic [1:0] left_input_mode,
   input logic       left_common_rejection_on,
   input logic       left_cmr_active,
   input logic [1:0] left_negative_pin_pick,
   input logic [1:0] left_positive_pin_pick,
   input logic [2:0] left_inv_pins,
   input logic [2:0] left_noninv_pins,
   input logic [1:0] right_negative_pin_pick,
   input logic [1:0] right_positive_pin_pick,
   input logic [2:0] right_inv_pins,
   input logic [2:0] right_noninv_pins,
   input logic       left_mode_reserved
);
   // ========================================================
   // helpers
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   function automatic logic [2:0] oh(logic [1:0] s);
      return s[1] ? 3'h4 : (s[0] ? 3'h2 : 3'h1);
   endfunction
   // ========================================================
   // assertions
   a_read_answer: assert property ($rose(s_axi_rvalid) |->
      $past(s_axi_arvalid && s_axi_arready)) else $error("late rvalid");
   a_read_release: assert property (s_axi_rvalid && s_axi_rready |=>
      !s_axi_rvalid) else $error("rvalid held");
   a_mute_reset: assert property ($rose(nrst) |-> right_amp_silence &&
      right_amp_gain_code == 5'h05) else $error("bad reset gain");
   a_line_floor: assert property (!right_input_mode[1] &&
      right_amp_gain_code == 5'h00 |=> right_gain_tenth_db == 10'h3F1)
      else $error("line gain floor");
   a_mic_ceiling: assert property (right_input_mode[1] &&
      right_amp_gain_code >= 5'h07 |=> right_gain_tenth_db == 10'h12C)
      else $error("mic gain ceiling");
   a_mic_invalid: assert property (right_gain_invalid ==
      $past(right_input_mode[1] && right_amp_gain_code == 5'h00))
      else $error("invalid flag");
   a_cmr_left: assert property (left_cmr_active == $past(
      left_common_rejection_on && left_input_mode == 2'h1))
      else $error("left rejection");
   a_pins_left: assert property (left_inv_pins == $past(
      left_input_mode[1] ? oh(left_positive_pin_pick) :
      oh(left_negative_pin_pick)) && left_noninv_pins == $past(
      left_input_mode[1] ? oh(left_negative_pin_pick) :
      oh(left_positive_pin_pick))) else $error("left pins");
   a_pins_right: assert property (right_inv_pins == $past(
      right_input_mode[1] ? oh(right_positive_pin_pick) :
      oh(right_negative_pin_pick)) && right_noninv_pins == $past(
      right_input_mode[1] ? oh(right_negative_pin_pick) :
      oh(right_positive_pin_pick))) else $error("right pins");
   a_mode_rsvd: assert property (left_mode_reserved ==
      $past(left_input_mode == 2'h3)) else $error("reserved mode");
   c_mic: cover property (right_gain_invalid);
   c_rsvd: cover property (left_mode_reserved);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule // aipc_regs_asserts

bind aipc_regs aipc_regs_asserts i_chk (.clk_sys, .nrst, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .right_amp_silence,
   .right_amp_gain_code, .right_gain_tenth_db, .right_gain_invalid,
   .right_input_mode, .left_input_mode, .left_common_rejection_on,
   .left_cmr_active, .left_negative_pin_pick, .left_positive_pin_pick,
   .left_inv_pins, .left_noninv_pins, .right_negative_pin_pick,
   .right_positive_pin_pick, .right_inv_pins, .right_noninv_pins,
   .left_mode_reserved);

// *** tb.sv ***
// Purpose : self-checking bench for the input path register bank
// Assumes : AXI4-Lite master driven at rising edges
// Notes   : expectations come from a shadow copy of the registers
`timescale 1ns/1ns
`include "aipc_defs.vh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin mismatches++; \
   $display("Error %0t: got %h exp %h", $time, a, e); end end
module tb;
   // ========================================================
   // signals
   logic        clk_sys = 0, nrst = 0;
   logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [2:0]  s_axi_awprot = 0, s_axi_arprot = 0;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0;
   logic [31:0] s_axi_wdata = 0;
   logic [3:0]  s_axi_wstrb = 0;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire         s_axi_rvalid, right_amp_silence, right_gain_invalid;
   wire         left_common_rejection_on, right_common_rejection_on;
   wire         left_cmr_active, right_cmr_active;
   wire         left_mode_reserved, right_mode_reserved;
   wire [1:0]   s_axi_bresp, s_axi_rresp, left_input_mode, right_input_mode;
   wire [1:0]   left_negative_pin_pick, left_positive_pin_pick;
   wire [1:0]   right_negative_pin_pick, right_positive_pin_pick;
   wire [2:0]   left_inv_pins, left_noninv_pins;
   wire [2:0]   right_inv_pins, right_noninv_pins;
   wire [4:0]   right_amp_gain_code;
   wire [9:0]   right_gain_tenth_db;
   wire [31:0]  s_axi_rdata;
   int          mismatches = 0, checked = 0;
   logic [31:0] rnd = 32'h9EFCD094;
   logic [15:0] m [3];
   // line law in tenths of a dB
   localparam int LT [32] = '{-15, -13, -10, -7, -3, 0, 3, 7, 10, 14, 18,
      23, 27, 32, 37, 42, 48, 54, 60, 67, 75, 83, 92, 102, 114, 127, 143,
      162, 192, 223, 252, 283};

   aipc_regs i_dut (.*);

   always #5 clk_sys = ~clk_sys;

   // ========================================================
   // expectation helpers
   function automatic logic [31:0] lfsr(logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic nxt;
      rnd = lfsr(rnd);
   endtask
   function automatic logic [2:0] oh(logic [1:0] s);
      return s[1] ? 3'h4 : (s[0] ? 3'h2 : 3'h1);
   endfunction
   function automatic logic [9:0] gexp(logic [1:0] md, logic [4:0] c);
      int v;
      if (!md[1]) v = LT[c];
      else if (c == 0) v = 0;
      else if (c >= 7) v = 300;
      else v = 90 + 30 * c;
      return v[9:0];
   endfunction
   function automatic int slot(logic [7:0] a);
      case (a[7:2])
         `AIPC_IDX_RGAIN: return 0;
         `AIPC_IDX_LROUTE: return 1;
         `AIPC_IDX_RROUTE: return 2;
         default: return 3;
      endcase
   endfunction

   // ========================================================
   // bus cycles
   task automatic put(logic [7:0] a, logic [31:0] d, logic [3:0] s);
      int k;
      logic [15:0] bm;
      k = slot(a);
      bm = {{8{s[1]}}, {8{s[0]}}} & (k == 0 ? `AIPC_MASK_RGAIN :
         `AIPC_MASK_ROUTE);
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      `CHK(s_axi_bresp, k < 3 ? `AIPC_RESP_OKAY : `AIPC_RESP_SLVERR)
      if (k < 3) m[k] = (m[k] & ~bm) | (d[15:0] & bm);
   endtask
   task automatic get(logic [7:0] a);
      int k;
      k = slot(a);
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      `CHK(s_axi_rdata, k < 3 ? {16'h0, m[k]} : 32'h0)
      `CHK(s_axi_rresp, k < 3 ? `AIPC_RESP_OKAY : `AIPC_RESP_SLVERR)
   endtask
   // decoded outputs settle one cycle after the write answer
   task automatic chk_out;
      logic [15:0] g, l, r;
      @(negedge clk_sys);
      g = m[0];
      l = m[1];
      r = m[2];
      `CHK(right_amp_silence, g[7])
      `CHK(right_amp_gain_code, g[4:0])
      `CHK(right_gain_tenth_db, gexp(r[1:0], g[4:0]))
      `CHK(right_gain_invalid, r[1] && g[4:0] == 0)
      `CHK(left_cmr_active, l[6] && l[1:0] == 1)
      `CHK(right_cmr_active, r[6] && r[1:0] == 1)
      `CHK(left_inv_pins, oh(l[1] ? l[3:2] : l[5:4]))
      `CHK(left_noninv_pins, oh(l[1] ? l[5:4] : l[3:2]))
      `CHK(right_inv_pins, oh(r[1] ? r[3:2] : r[5:4]))
      `CHK(right_noninv_pins, oh(r[1] ? r[5:4] : r[3:2]))
      `CHK(left_mode_reserved, l[1:0] == 3)
      `CHK(right_mode_reserved, r[1:0] == 3)
      `CHK(left_common_rejection_on, l[6])
      `CHK(right_common_rejection_on, r[6])
      `CHK(left_input_mode, l[1:0])
      `CHK(right_input_mode, r[1:0])
      `CHK({left_negative_pin_pick, left_positive_pin_pick}, l[5:2])
      `CHK({right_negative_pin_pick, right_positive_pin_pick}, r[5:2])
   endtask
   task automatic wrap_up;
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // ========================================================
   // sequence
   initial begin
      logic [7:0] a;
      m[0] = 16'h0085;
      m[1] = 16'h0044;
      m[2] = 16'h0044;
      repeat (4) @(posedge clk_sys);
      nrst <= 1'b1;
      chk_out;
      get(8'hB4);
      get(8'hB8);
      get(8'hBC);
      get(8'h00);
      // every mode on both channels against the whole gain range
      for (int md = 0; md < 4; md++) begin
         nxt;
         put(8'hB8, {rnd[31:2], md[1:0]}, 4'hF);
         nxt;
         put(8'hBC, {rnd[31:2], md[1:0]}, 4'hF);
         for (int c = 0; c < 32; c++) begin
            nxt;
            put(8'hB4, {rnd[31:5], c[4:0]}, 4'hF);
            chk_out;
         end
         get(8'hB8);
      end
      // random places, data and lanes, unmapped words among them
      for (int i = 0; i < 60; i++) begin
         nxt;
         a = rnd[1:0] == 2'h3 ? rnd[9:2] & 8'hFC : 8'hB4 + {rnd[1:0], 2'h0};
         nxt;
         put(a, rnd, rnd[19:16]);
         get(a);
         chk_out;
      end
      wrap_up;
   end
   initial begin
      #500000;
      mismatches++;
      wrap_up;
   end
endmodule // tb
